/* hw/dbu_pkg.sv */
// Package for the debug unlock and reset handshake block.
// Shared widths, codes and timing counts; no module logic.
package dbu_pkg;
   localparam int DBU_WORD_W = 32;
   localparam int DBU_NCORE = 2;
   // Password length after a key swap request
   localparam logic [3:0] DBU_PW_WORDS = 4'h8;
   // Key swap request code; arbitrary value
   localparam logic [31:0] DBU_KEY_SWAP_REQ = 32'h4b455953;
   // Reset value of the comm register
   localparam logic [31:0] DBU_COMM_RST = 32'h00000000;
   // Unlock window length between first and second point, in ns
   localparam int DBU_WINDOW_NS = 2000;
   localparam int DBU_CLK_NS = 5;
   localparam int DBU_WINDOW_CYC = DBU_WINDOW_NS / DBU_CLK_NS;
   localparam logic [15:0] DBU_WINDOW_CNT = 16'(DBU_WINDOW_CYC);
   // Positions in the tool configuration byte
   localparam int DBU_CFG_APP_RST = 7;
endpackage

/* hw/dbu_sync.sv */
// Two-flop synchroniser for signals arriving from outside clk_i.
// Assumes the source is a level with no meaning between edges.
`timescale 1ns/1ps
module dbu_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
   } dbu_sync_t;
   dbu_sync_t st;
   dbu_sync_t next_st;
   always_comb begin
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign q_o = st.s2;
endmodule

/* hw/dbu_core.sv */
// Debug unlock, reset request and halt-retention logic of the device.
// Assumes tool accesses arrive as a serial link clocked by link_clk_i,
// and firmware steps arrive as single-cycle strobes on clk_i.
//
// Behaviour
// R01: After power-on reset firmware puts the serial word into the comm register, opening the window.
// R02: At the second point, a key swap request in the register lets firmware take exactly 8 words.
// R03: Without the request at the second point, the serial word is rewritten and the lock stays.
// R04: The tool writes the key swap request between the two points, after seeing the serial word.
// R05: During self-test the debug interface is disabled and gives no response.
// R06: The app reset request bit raises an app reset request until the tool clears it.
// R07: The tool runs its clock above 1 MHz and releases the request twice back to back.
// R08: On the two-pin port the first release may fail but the second always takes effect.
// R09: Debug state survives system and app reset; a halted boot core halts startup again.
// R10: The tool moves the core to run before system or app resets, or uses power-on reset.
// R11: After a system or app reset, a lockstep alarm rises when enabled, debug on, and halted or counting.
// R12: The tool avoids the alarm by disabling debug, unhalting cores or using power-on reset.
// R13: The comm register is read and written by tool and firmware, last writer wins.
`timescale 1ns/1ps
module dbu_core
   import dbu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sys_rst_i,
   input wire logic app_rst_i,
   input wire logic selftest_busy_i,
   input wire logic link_clk_i,
   input wire logic link_sel_i,
   input wire logic link_wr_i,
   input wire logic [DBU_WORD_W-1:0] link_wdata_i,
   input wire logic link_cfg_i,
   input wire logic [7:0] link_cfg_data_i,
   input wire logic two_pin_mode_i,
   input wire logic [DBU_WORD_W-1:0] per_die_serial_word_i,
   input wire logic fw_rd_i,
   input wire logic fw_wr_i,
   input wire logic [DBU_WORD_W-1:0] fw_wdata_i,
   input wire logic device_locked_i,
   input wire logic halt_req_i,
   input wire logic run_req_i,
   input wire logic [DBU_NCORE-1:0] lockstep_enable_bit_i,
   input wire logic debug_system_enable_bit_i,
   input wire logic [DBU_NCORE-1:0] core_halted_i,
   input wire logic [DBU_NCORE-1:0] perf_cnt_en_i,
   output logic [DBU_WORD_W-1:0] debug_comm_data_reg_o,
   output logic link_resp_o,
   output logic [7:0] tool_config_reg_o,
   output logic app_reset_req_o,
   output logic unlocked_o,
   output logic pw_taking_o,
   output logic boot_halt_o,
   output logic [DBU_NCORE-1:0] lockstep_alarm_o
);
   // ======================================================
   // Link sampling
   logic lclk_s;
   logic sel_s;
   logic wr_s;
   logic cfg_s;
   logic bist_s;
   logic [DBU_WORD_W-1:0] wdata_s1;
   logic [DBU_WORD_W-1:0] wdata_s2;
   logic [7:0] cdata_s1;
   logic [7:0] cdata_s2;
   dbu_sync u_sclk (.clk_i(clk_i), .rst_i(rst_i), .d_i(link_clk_i), .q_o(lclk_s));
   dbu_sync u_ssel (.clk_i(clk_i), .rst_i(rst_i), .d_i(link_sel_i), .q_o(sel_s));
   dbu_sync u_swr (.clk_i(clk_i), .rst_i(rst_i), .d_i(link_wr_i), .q_o(wr_s));
   dbu_sync u_scfg (.clk_i(clk_i), .rst_i(rst_i), .d_i(link_cfg_i), .q_o(cfg_s));
   dbu_sync u_sbist (.clk_i(clk_i), .rst_i(rst_i), .d_i(selftest_busy_i), .q_o(bist_s));
   // Data is stable around the link edge, so a two-stage copy suffices
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wdata_s1 <= '0;
         wdata_s2 <= '0;
         cdata_s1 <= '0;
         cdata_s2 <= '0;
      end else begin
         wdata_s1 <= link_wdata_i;
         wdata_s2 <= wdata_s1;
         cdata_s1 <= link_cfg_data_i;
         cdata_s2 <= cdata_s1;
      end
   end

   // ======================================================
   // State
   typedef enum {DBU_IDLE, DBU_WINDOW, DBU_PASSWORD, DBU_DONE} dbu_ph_t;
   typedef struct packed {
      dbu_ph_t ph;
      logic lclk_d;
      logic [DBU_WORD_W-1:0] comm;
      logic [15:0] win_cnt;
      logic [3:0] pw_cnt;
      logic unlocked;
      logic [7:0] cfg;
      logic rel_seen;
      logic halt_kept;
      logic [DBU_NCORE-1:0] alarm;
      logic resp;
   } dbu_st_t;
   dbu_st_t st;
   dbu_st_t next_st;
   logic ledge;
   logic tool_wr;
   logic tool_cfg;
   logic wreset;
   logic [DBU_NCORE-1:0] alarm_cond;

   assign ledge = lclk_s & ~st.lclk_d;
   // Tool is ignored entirely while self-test runs
   assign tool_wr = ledge & sel_s & wr_s & ~bist_s; // see R05
   assign tool_cfg = ledge & sel_s & cfg_s & ~bist_s; // see R05
   assign wreset = sys_rst_i | app_rst_i;
   assign alarm_cond = lockstep_enable_bit_i & {DBU_NCORE{debug_system_enable_bit_i}}
                       & (core_halted_i | perf_cnt_en_i); // see R11

   always_comb begin
      next_st = st;
      next_st.lclk_d = lclk_s;
      next_st.resp = ledge & sel_s & ~bist_s; // see R05
      // Tool write before firmware: firmware steps are the later writer
      if (tool_wr) begin
         next_st.comm = wdata_s2; // see R13
      end
      if (fw_wr_i) begin
         next_st.comm = fw_wdata_i; // see R13
      end
      if (tool_cfg) begin
         // Two-pin port: the first release after a request may be lost,
         // the second always lands
         if (two_pin_mode_i && st.cfg[DBU_CFG_APP_RST] && !cdata_s2[DBU_CFG_APP_RST]
             && !st.rel_seen) begin
            next_st.rel_seen = 1'b1; // see R08
            next_st.cfg = {1'b1, cdata_s2[DBU_CFG_APP_RST-1:0]};
         end else begin
            next_st.cfg = cdata_s2; // see R06
            next_st.rel_seen = 1'b0;
         end
      end
      case (st.ph)
         DBU_IDLE: begin
            next_st.comm = per_die_serial_word_i; // see R01
            next_st.win_cnt = DBU_WINDOW_CNT;
            next_st.ph = DBU_WINDOW;
         end
         DBU_WINDOW: begin
            if (st.win_cnt > 16'h0001) begin
               next_st.win_cnt = st.win_cnt - 16'h0001;
            end else if (st.comm == DBU_KEY_SWAP_REQ) begin
               next_st.pw_cnt = 4'h0; // see R02
               next_st.ph = DBU_PASSWORD;
            end else begin
               next_st.comm = per_die_serial_word_i; // see R03
               next_st.unlocked = ~device_locked_i; // see R03
               next_st.ph = DBU_DONE;
            end
         end
         DBU_PASSWORD: begin
            if (fw_rd_i) begin
               next_st.pw_cnt = st.pw_cnt + 4'h1; // see R02
               if (st.pw_cnt + 4'h1 == DBU_PW_WORDS) begin
                  next_st.unlocked = 1'b1;
                  next_st.ph = DBU_DONE;
               end
            end
         end
         DBU_DONE: begin
         end
         default: next_st.ph = DBU_IDLE;
      endcase
      // Debug state survives system and app reset; only run_req_i or power-on reset clears the halt
      if (halt_req_i) begin
         next_st.halt_kept = 1'b1; // see R09
      end else if (run_req_i) begin
         next_st.halt_kept = 1'b0;
      end
      if (wreset) begin
         next_st.alarm = st.alarm | alarm_cond; // see R11
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st.ph <= DBU_IDLE;
         st.lclk_d <= 1'b0;
         st.comm <= DBU_COMM_RST;
         st.win_cnt <= 16'h0000;
         st.pw_cnt <= 4'h0;
         st.unlocked <= 1'b0;
         st.cfg <= 8'h00;
         st.rel_seen <= 1'b0;
         st.halt_kept <= 1'b0;
         st.alarm <= '0;
         st.resp <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign debug_comm_data_reg_o = st.comm;
   assign link_resp_o = st.resp;
   assign tool_config_reg_o = st.cfg;
   assign app_reset_req_o = st.cfg[DBU_CFG_APP_RST]; // see R06
   assign unlocked_o = st.unlocked;
   assign pw_taking_o = (st.ph == DBU_PASSWORD);
   assign boot_halt_o = st.halt_kept; // see R09
   assign lockstep_alarm_o = st.alarm;

   // ======================================================
   // Checks
   AST_SERIAL_FIRST: assert property (@(posedge clk_i) disable iff (rst_i) // see R01
      st.ph == DBU_IDLE |=> debug_comm_data_reg_o == $past(per_die_serial_word_i))
      else $error("serial word not placed at first point");
   AST_PW_ENTER: assert property (@(posedge clk_i) disable iff (rst_i) // see R02
      (st.ph == DBU_WINDOW && st.win_cnt <= 16'h0001 && st.comm == DBU_KEY_SWAP_REQ)
      |=> pw_taking_o && st.pw_cnt == 4'h0)
      else $error("key swap request not accepted");
   AST_NO_REQ: assert property (@(posedge clk_i) disable iff (rst_i) // see R03
      (st.ph == DBU_WINDOW && st.win_cnt <= 16'h0001 && st.comm != DBU_KEY_SWAP_REQ
       && device_locked_i) |=> !unlocked_o && st.ph == DBU_DONE)
      else $error("locked device unlocked without request");
   AST_SELFTEST_QUIET: assert property (@(posedge clk_i) disable iff (rst_i) // see R05
      bist_s |=> !link_resp_o)
      else $error("response during self-test");
   AST_APP_REQ: assert property (@(posedge clk_i) disable iff (rst_i) // see R06
      (tool_cfg && cdata_s2[DBU_CFG_APP_RST]) |=> app_reset_req_o)
      else $error("app reset request not raised");
   AST_SECOND_REL: assert property (@(posedge clk_i) disable iff (rst_i) // see R08
      (tool_cfg && !cdata_s2[DBU_CFG_APP_RST] && st.rel_seen) |=> !app_reset_req_o)
      else $error("second release did not take effect");
   AST_HALT_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // see R09
      (boot_halt_o && wreset && !run_req_i) |=> boot_halt_o)
      else $error("halt lost on warm reset");
   AST_ALARM: assert property (@(posedge clk_i) disable iff (rst_i) // see R11
      (wreset && alarm_cond != '0) |=> (lockstep_alarm_o & $past(alarm_cond)) == $past(alarm_cond))
      else $error("lockstep alarm not raised");
   AST_LAST_WRITER: assert property (@(posedge clk_i) disable iff (rst_i) // see R13
      (fw_wr_i && st.ph == DBU_DONE) |=> debug_comm_data_reg_o == $past(fw_wdata_i))
      else $error("firmware write lost");
endmodule

/* tb/dbu_tool.sv */
// Model of the external debug tool that drives the link frames.
// Assumes the core finds link clock edges with its own fast clock.
`timescale 1ns/1ps
module dbu_tool
   import dbu_pkg::*;
(
   output logic link_clk_o,
   output logic link_sel_o,
   output logic link_wr_o,
   output logic link_cfg_o,
   output logic [DBU_WORD_W-1:0] link_wdata_o,
   output logic [7:0] link_cfg_data_o
);
   // ==========================================
   // Frames
   initial link_clk_o = 1'b0;
   initial {link_sel_o, link_wr_o, link_cfg_o, link_wdata_o, link_cfg_data_o} = '0;
   // 190 ns link period keeps the tool clock above 1 MHz
   // Clock stands low between frames and released data is inverted,
   // so a core that samples outside the frame sees garbage, not the old word
   task automatic send(input logic cfg, input logic [DBU_WORD_W-1:0] d);
      link_sel_o = 1'b1;
      link_wr_o = ~cfg;
      link_cfg_o = cfg;
      link_wdata_o = d;
      link_cfg_data_o = d[7:0];
      // A 60/65/65 ns split gives a 190 ns period with every change while the link clock is low
      #60 link_clk_o = 1'b1;
      #65 link_clk_o = 1'b0;
      {link_sel_o, link_wr_o, link_cfg_o} = 3'h0;
      link_wdata_o = ~d;
      link_cfg_data_o = ~d[7:0];
      #65;
   endtask
   // Release sent twice back to back
   task automatic release2;
      send(1'b1, 32'h00000000);
      send(1'b1, 32'h00000000);
   endtask
endmodule

/* tb/debug_unlock_reset_handshake_tb.sv */
// Self-checking bench for the debug unlock and reset handshake core.
// Assumes dbu_pkg, dbu_core and the tool model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module debug_unlock_reset_handshake_tb
   import dbu_pkg::*;
;
   // ==========================================
   // Signals and instances
   logic clk_i = 1'b0, rst_i = 1'b1, sys_rst_i = 1'b0, app_rst_i = 1'b0;
   logic selftest_busy_i = 1'b0, two_pin_mode_i = 1'b0, fw_rd_i = 1'b0, fw_wr_i = 1'b0;
   logic halt_req_i = 1'b0, run_req_i = 1'b0, device_locked_i = 1'b1;
   logic debug_system_enable_bit_i = 1'b0;
   logic [DBU_WORD_W-1:0] per_die_serial_word_i = 32'h5e71a001, fw_wdata_i = 32'h0;
   logic [DBU_NCORE-1:0] lockstep_enable_bit_i = 2'h0, core_halted_i = 2'h0, perf_cnt_en_i = 2'h0;
   logic link_clk_i, link_sel_i, link_wr_i, link_cfg_i, link_resp_o, app_reset_req_o;
   logic unlocked_o, pw_taking_o, boot_halt_o;
   logic [DBU_WORD_W-1:0] link_wdata_i, debug_comm_data_reg_o;
   logic [7:0] link_cfg_data_i, tool_config_reg_o;
   logic [DBU_NCORE-1:0] lockstep_alarm_o;
   int bad_count = 0, compares = 0, resp_n = 0;
   dbu_tool tool (.link_clk_o(link_clk_i), .link_sel_o(link_sel_i), .link_wr_o(link_wr_i),
      .link_cfg_o(link_cfg_i), .link_wdata_o(link_wdata_i), .link_cfg_data_o(link_cfg_data_i));
   dbu_core dut (.clk_i, .rst_i, .sys_rst_i, .app_rst_i, .selftest_busy_i, .link_clk_i,
      .link_sel_i, .link_wr_i, .link_wdata_i, .link_cfg_i, .link_cfg_data_i, .two_pin_mode_i,
      .per_die_serial_word_i, .fw_rd_i, .fw_wr_i, .fw_wdata_i, .device_locked_i, .halt_req_i,
      .run_req_i, .lockstep_enable_bit_i, .debug_system_enable_bit_i, .core_halted_i,
      .perf_cnt_en_i, .debug_comm_data_reg_o, .link_resp_o, .tool_config_reg_o,
      .app_reset_req_o, .unlocked_o, .pw_taking_o, .boot_halt_o, .lockstep_alarm_o);
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (link_resp_o === 1'b1) resp_n++;
   // ==========================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task automatic do_rst;
      rst_i = 1'b1;
      cyc(8);
      rst_i = 1'b0;
      cyc(4);
   endtask
   // Fixed 20-cycle look covers sync latency plus the answer pulse
   task automatic tx(input logic cfg, input logic [DBU_WORD_W-1:0] d, input logic exp);
      int n0;
      n0 = resp_n;
      tool.send(cfg, d);
      cyc(20);
      `CHK(resp_n != n0, exp)
   endtask
   task automatic conclude;
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
   // ==========================================
   // Sequence
   initial begin
      do_rst();
      `CHK(debug_comm_data_reg_o, per_die_serial_word_i)
      tx(1'b0, DBU_KEY_SWAP_REQ, 1'b1);
      `CHK(debug_comm_data_reg_o, DBU_KEY_SWAP_REQ)
      cyc(DBU_WINDOW_CYC);
      `CHK(pw_taking_o, 1'b1)
      for (int i = 0; i < int'(DBU_PW_WORDS); i++) begin
         `CHK(unlocked_o, 1'b0)
         pulse(fw_rd_i);
      end
      `CHK(unlocked_o, 1'b1)
      fw_wdata_i = 32'h1234abcd;
      pulse(fw_wr_i);
      `CHK(debug_comm_data_reg_o, 32'h1234abcd)
      do_rst();
      tx(1'b0, 32'h000000a5, 1'b1);
      cyc(DBU_WINDOW_CYC);
      `CHK(debug_comm_data_reg_o, per_die_serial_word_i)
      `CHK({pw_taking_o, unlocked_o}, 2'h0)
      selftest_busy_i = 1'b1;
      cyc(4);
      tx(1'b0, 32'h0000003c, 1'b0);
      selftest_busy_i = 1'b0;
      cyc(4);
      `CHK(debug_comm_data_reg_o, per_die_serial_word_i)
      tx(1'b1, 32'h00000080, 1'b1);
      `CHK({app_reset_req_o, tool_config_reg_o}, 9'h180)
      tool.release2();
      cyc(20);
      `CHK(app_reset_req_o, 1'b0)
      two_pin_mode_i = 1'b1;
      tx(1'b1, 32'h00000080, 1'b1);
      tx(1'b1, 32'h00000000, 1'b1);
      `CHK(app_reset_req_o, 1'b1)
      tx(1'b1, 32'h00000000, 1'b1);
      `CHK(app_reset_req_o, 1'b0)
      pulse(halt_req_i);
      lockstep_enable_bit_i = 2'h3;
      core_halted_i = 2'h1;
      perf_cnt_en_i = 2'h2;
      pulse(sys_rst_i);
      `CHK(lockstep_alarm_o, 2'h0)
      `CHK(boot_halt_o, 1'b1)
      debug_system_enable_bit_i = 1'b1;
      pulse(app_rst_i);
      `CHK(lockstep_alarm_o, 2'h3)
      `CHK(boot_halt_o, 1'b1)
      pulse(run_req_i);
      `CHK(boot_halt_o, 1'b0)
      pulse(halt_req_i);
      device_locked_i = 1'b0;
      do_rst();
      `CHK({boot_halt_o, lockstep_alarm_o}, 3'h0)
      cyc(DBU_WINDOW_CYC);
      `CHK({pw_taking_o, unlocked_o}, 2'h1)
      conclude();
   end
endmodule
